// File: bus_master_model.sv
// serial bus master model pulling scl and sda as open-drain lines
// assumes the bench resolves both wires with pull-ups
`timescale 1ns/1ps
module bus_master_model (
    // clock and resolved data line
    input  wire logic ref_clk,
    input  wire logic sda_line,
    // pulls, high drags the wire low
    output logic      scl_low,
    output logic      sda_low
);
    // both wires released at time zero
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // start, also a repeated start from a low clock
    task automatic start();
        sda_low = 1'b0;
        wait_n(8);
        scl_low = 1'b0;
        wait_n(8);
        sda_low = 1'b1;
        wait_n(8);
        scl_low = 1'b1;
        wait_n(2);
    endtask
    task automatic stop();
        sda_low = 1'b1;
        wait_n(8);
        scl_low = 1'b0;
        wait_n(8);
        sda_low = 1'b0;
        wait_n(8);
    endtask
    // data moves 2 cycles into the low phase so no false start or stop
    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        wait_n(8);
        scl_low = 1'b0;
        wait_n(4);
        r = sda_line;
        wait_n(4);
        scl_low = 1'b1;
        wait_n(2);
    endtask
    // last high gives a nack on reads; writes release for the slave ack
    task automatic byte_io(input logic [7:0] d, input logic last,
                           output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(last, ack);
    endtask
endmodule

// File: monitor_readback_map.svh
// register codes, field positions and reset values of the monitor readback
// assumes inclusion by bare name from the package and the design file
`ifndef MONITOR_READBACK_MAP_SVH
`define MONITOR_READBACK_MAP_SVH

// extended register pointer codes (low bits of the pointer byte)
`define EXT_ALERT_EN     2'h1
`define EXT_ALERT_TH     2'h2
`define EXT_CONTROL      2'h3
// pointer byte flag: msb set means extended write
`define PTR_EXT_BIT      7
// command byte fields
`define CMD_V_CONT       0
`define CMD_V_ONCE       1
`define CMD_I_CONT       2
`define CMD_I_ONCE       3
`define CMD_STATUS_SEL   6
`define CMD_RESET        7'h00
// alert enable fields
`define EN_COMPARATOR_ALERT_LATCHED      2
`define EN_OFF_ALERT     3
`define EN_CLEAR         4
`define ALERT_EN_RESET   8'h04
`define ALERT_TH_RESET   8'hFF
`define CONTROL_RESET    8'h00
// control fields
`define CTL_SOFTWARE_OFF 0
// status byte fields
`define ST_ADC_OVERCURRENT_SEEN        0
`define ST_ADC_ALERT     1
`define ST_COMP_OC       2
`define ST_COMP_ALERT    3
`define ST_OFF_FLAG      4
`define ST_OFF_ALERT     5
// byte counts and fillers
`define BITS_PER_BYTE    4'h8
`define IDLE_BYTE        8'hFF
`define ZERO_NIBBLE      4'h0
`define ZERO_BYTE        8'h00

`endif

// File: monitor_readback_pkg.sv
// types shared by the monitor readback design
// assumes the map header sits in the same folder
package monitor_readback_pkg;
    `include "monitor_readback_map.svh"

    // readback layouts chosen from the conversion command bits
    typedef enum logic [1:0] {
        LAYOUT_BOTH,
        LAYOUT_VOLT,
        LAYOUT_AMP
    } layout_t;

    // serial slave states
    typedef enum logic [2:0] {
        SER_IDLE,
        SER_ADDR,
        SER_ADDR_ACK,
        SER_WR,
        SER_WR_ACK,
        SER_RD,
        SER_RD_ACK
    } ser_state_t;
endpackage

// File: monitor_readback_props.sv
// assertions on the monitor readback ports
// assumes it is bound into the design and scl_in is the raw pin level
`timescale 1ns/1ps
module monitor_readback_props #(
    parameter int FAULT_DELAY_CYCLES = 1000
) (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       srst,
    // watched pins and registers
    input wire logic       scl_in,
    input wire logic       sda_oe,
    input wire logic       adc_trip,
    input wire logic       comparator_overcurrent,
    input wire logic [6:0] conv_command,
    input wire logic [7:0] alert_enable,
    input wire logic [7:0] alert_threshold,
    input wire logic       alert_oe
);
    logic [15:0] hi_cnt_reg;
    logic [15:0] hi_cnt_next;

    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    // raw comparator high time, saturating so long faults never wrap
    assign hi_cnt_next = !comparator_overcurrent ? 16'h0000 :
                         (&hi_cnt_reg) ? hi_cnt_reg : hi_cnt_reg + 16'h0001;
    always_ff @(posedge ref_clk) begin
        hi_cnt_reg <= srst ? 16'h0000 : hi_cnt_next;
    end

    // bus clock fallen and held low for a whole answer window
    sequence s_low_held;
        $fell(scl_in) ##1 !scl_in [*7];
    endsequence

    a_reset_pins: assert property ($fell(srst) |-> alert_oe && !sda_oe)
        else $error("pins not idle after reset");
    a_reset_regs: assert property ($fell(srst) |-> alert_enable == 8'h04
        && alert_threshold == 8'hFF && conv_command == 7'h00)
        else $error("register reset values wrong");
    a_no_early_fault: assert property ($fell(alert_oe)
        && comparator_overcurrent && !alert_enable[3] && !adc_trip
        && !$past(adc_trip) && !$past(adc_trip, 2)
        |-> hi_cnt_reg >= 16'(FAULT_DELAY_CYCLES))
        else $error("fault pin asserted before delay ended");
    a_fault_on_time: assert property (hi_cnt_reg ==
        16'(FAULT_DELAY_CYCLES + 8) && alert_enable[2] && !alert_enable[3]
        |-> !alert_oe)
        else $error("fault pin late after delay");
    a_release_cause: assert property ($rose(alert_oe) |-> alert_enable[3]
        || $past(alert_enable[4]) || $past(alert_enable[4], 2)
        || alert_enable != $past(alert_enable, 2))
        else $error("fault pin released without clear");
    a_clear_self: assert property (alert_enable[4] |=> !alert_enable[4])
        else $error("clear bit did not return to zero");
    a_sda_low_phase: assert property ($changed(sda_oe)
        |-> !scl_in && !$past(scl_in, 2))
        else $error("data pin moved outside low clock phase");
    a_answer_settled: assert property (s_low_held |-> $stable(sda_oe))
        else $error("data pin still moving late in low phase");
    a_adc_trip_fault: assert property (adc_trip && alert_enable[0]
        && !alert_enable[3] |-> ##[1:3] !alert_oe)
        else $error("converter trip did not raise fault");
endmodule

bind monitor_readback_status_alert monitor_readback_props #(
    .FAULT_DELAY_CYCLES(FAULT_DELAY_CYCLES)
) monitor_readback_props_i (
    .ref_clk(ref_clk), .srst(srst), .scl_in(scl_in), .sda_oe(sda_oe),
    .adc_trip(adc_trip), .comparator_overcurrent(comparator_overcurrent),
    .conv_command(conv_command), .alert_enable(alert_enable),
    .alert_threshold(alert_threshold), .alert_oe(alert_oe)
);

// File: monitor_readback_status_alert.sv
// serial slave, readback layouts, status byte and fault output of the monitor
// assumes codes and trip inputs arrive on ref_clk; scl, sda and the
// comparator come from pins and are synchronised here
//
// Behaviour
// - software_off drives fault output to deasserted level when off_alert_enable high
// - readback layout picked from conversion bits: both, voltage, or current
// - combined read: volt msbs, amp msbs, then volt and amp nibbles
// - voltage read: volt msbs, then volt nibble above four zeros
// - current read: amp msbs, then amp nibble above four zeros
// - read: start, address with read bit, slave acks, master acks, nack, stop
// - status select makes a read return one status byte
// - clear bit wipes status bits one, three and five
// - status bit zero shows converter overcurrent on last three conversions
// - status bit one latches a converter-based trip until cleared
// - status bit two follows the comparator live, unlatched
// - status bit three latches a comparator fault that raised the output
// - status bit four set when software_off written high
// - status bit five latches an alert caused by software_off
// - fault pin driven low normally, released high on a fault
// - comparator starts the delay; fault asserts only when delay completes
// - status_select command bit turns later reads into status reads
// - clear bit self-clears after clearing; sources may set bits again
// - off_alert_enable lets software_off raise an alert and override output
`timescale 1ns/1ps
`include "monitor_readback_map.svh"

module monitor_readback_status_alert #(
    parameter int FAULT_DELAY_CYCLES = 1000
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // serial bus pins, open drain
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // slave address, static strap level
    input  wire logic [6:0]  dev_addr,
    // converter side
    input  wire logic [11:0] volt_code,
    input  wire logic [11:0] amp_code,
    input  wire logic        adc_overcurrent_seen,
    input  wire logic        adc_trip,
    // analog comparator from pin
    input  wire logic        comparator_overcurrent,
    // configuration toward converter and threshold logic
    output logic [6:0]       conv_command,
    output logic [7:0]       alert_enable,
    output logic [7:0]       alert_threshold,
    // fault pin, open drain
    output logic             alert_out,
    output logic             alert_oe
);
    import monitor_readback_pkg::*;

    localparam logic [15:0] DELAY_LAST = 16'(FAULT_DELAY_CYCLES - 1);

    logic        scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, cmp_m, cmp_s;
    ser_state_t  state_reg;
    logic [3:0]  bit_cnt_reg;
    logic [7:0]  shift_reg;
    logic        rw_reg, drive_low_reg, ack_seen_reg;
    logic [1:0]  byte_idx_reg, ext_ptr_reg;
    logic        ext_sel_reg;
    logic [11:0] snap_v_reg, snap_i_reg;
    logic [6:0]  cmd_reg;
    logic [7:0]  alert_en_reg, alert_th_reg, control_reg;
    logic        clear_reg, adc_alert_reg, comp_alert_reg;
    logic        off_flag_reg, off_alert_reg;
    logic [15:0] delay_cnt_reg;

    // two-stage synchronisers, third stage only for edge detection
    always_ff @(posedge ref_clk) begin
        scl_m <= scl_in;
        scl_s <= scl_m;
        scl_d <= scl_s;
        sda_m <= sda_in;
        sda_s <= sda_m;
        sda_d <= sda_s;
        cmp_m <= comparator_overcurrent;
        cmp_s <= cmp_m;
    end

    // bus events seen on the synchronised lines
    wire scl_rise  = scl_s & ~scl_d;
    wire scl_fall  = ~scl_s & scl_d;
    wire start_ev  = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_ev   = scl_s & scl_d & ~sda_d & sda_s;
    wire byte_done = scl_fall && (bit_cnt_reg == `BITS_PER_BYTE);
    wire addr_hit  = (shift_reg[7:1] == dev_addr);

    // layout from conversion bits; no voltage or current bit means both
    wire v_sel = cmd_reg[`CMD_V_CONT] | cmd_reg[`CMD_V_ONCE];
    wire i_sel = cmd_reg[`CMD_I_CONT] | cmd_reg[`CMD_I_ONCE];
    layout_t layout;
    assign layout = (v_sel && !i_sel) ? LAYOUT_VOLT :
                    (i_sel && !v_sel) ? LAYOUT_AMP : LAYOUT_BOTH;

    // status byte, bit two is live and unlatched
    wire [7:0] status_byte = {2'b00, off_alert_reg, off_flag_reg,
                              comp_alert_reg, cmp_s, adc_alert_reg,
                              adc_overcurrent_seen};

    // byte formats, snapshots taken at address ack keep a read coherent
    wire [7:0] v_msb  = snap_v_reg[11:4];
    wire [7:0] i_msb  = snap_i_reg[11:4];
    wire [7:0] lsb_vi = {snap_v_reg[3:0], snap_i_reg[3:0]};
    wire [7:0] lsb_v  = {snap_v_reg[3:0], `ZERO_NIBBLE};
    wire [7:0] lsb_i  = {snap_i_reg[3:0], `ZERO_NIBBLE};
    wire       stat_rd = cmd_reg[`CMD_STATUS_SEL];
    logic [7:0] tx_byte;
    always_comb begin
        tx_byte = `IDLE_BYTE;
        if (stat_rd) begin
            if (byte_idx_reg == 2'd0) tx_byte = status_byte;
        end else begin
            case (layout)
                LAYOUT_BOTH: begin
                    if (byte_idx_reg == 2'd0) tx_byte = v_msb;
                    if (byte_idx_reg == 2'd1) tx_byte = i_msb;
                    if (byte_idx_reg == 2'd2) tx_byte = lsb_vi;
                end
                LAYOUT_VOLT: begin
                    if (byte_idx_reg == 2'd0) tx_byte = v_msb;
                    if (byte_idx_reg == 2'd1) tx_byte = lsb_v;
                end
                LAYOUT_AMP: begin
                    if (byte_idx_reg == 2'd0) tx_byte = i_msb;
                    if (byte_idx_reg == 2'd1) tx_byte = lsb_i;
                end
                default: tx_byte = `IDLE_BYTE;
            endcase
        end
    end

    // next read byte index saturates so overreads return the idle byte
    wire [1:0] idx_inc = (byte_idx_reg == 2'd3) ? byte_idx_reg
                                                : byte_idx_reg + 2'd1;

    // write strobes decoded from a received byte in the write phase
    wire wr_byte   = (state_reg == SER_WR) && byte_done;
    wire wr_cmd    = wr_byte && (byte_idx_reg == 2'd0)
                     && !shift_reg[`PTR_EXT_BIT];
    wire wr_ptr    = wr_byte && (byte_idx_reg == 2'd0)
                     && shift_reg[`PTR_EXT_BIT];
    wire wr_ext    = wr_byte && (byte_idx_reg == 2'd1) && ext_sel_reg;
    wire wr_en     = wr_ext && (ext_ptr_reg == `EXT_ALERT_EN);
    wire wr_th     = wr_ext && (ext_ptr_reg == `EXT_ALERT_TH);
    wire wr_ctl    = wr_ext && (ext_ptr_reg == `EXT_CONTROL);

    // serial slave: sample on scl rise, change sda on scl fall
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg     <= SER_IDLE;
            bit_cnt_reg   <= 4'h0;
            shift_reg     <= `ZERO_BYTE;
            rw_reg        <= 1'b0;
            drive_low_reg <= 1'b0;
            ack_seen_reg  <= 1'b0;
            byte_idx_reg  <= 2'd0;
        end else if (start_ev) begin
            state_reg     <= SER_ADDR;
            bit_cnt_reg   <= 4'h0;
            drive_low_reg <= 1'b0;
        end else if (stop_ev) begin
            state_reg     <= SER_IDLE;
            drive_low_reg <= 1'b0;
        end else begin
            if (scl_rise && state_reg != SER_RD && state_reg != SER_RD_ACK) begin
                shift_reg   <= {shift_reg[6:0], sda_s};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            case (state_reg)
                SER_IDLE: drive_low_reg <= 1'b0;
                SER_ADDR: if (byte_done) begin
                    if (addr_hit) begin
                        drive_low_reg <= 1'b1;
                        rw_reg        <= shift_reg[0];
                        byte_idx_reg  <= 2'd0;   // first byte of a read
                        state_reg     <= SER_ADDR_ACK;
                    end else begin
                        state_reg     <= SER_IDLE;
                    end
                end
                SER_ADDR_ACK: if (scl_fall) begin
                    bit_cnt_reg  <= 4'h0;
                    byte_idx_reg <= 2'd0;
                    if (rw_reg) begin
                        shift_reg     <= tx_byte;
                        drive_low_reg <= ~tx_byte[7];
                        state_reg     <= SER_RD;
                    end else begin
                        drive_low_reg <= 1'b0;
                        state_reg     <= SER_WR;
                    end
                end
                SER_WR: if (byte_done) begin
                    drive_low_reg <= 1'b1;
                    state_reg     <= SER_WR_ACK;
                end
                SER_WR_ACK: if (scl_fall) begin
                    drive_low_reg <= 1'b0;
                    bit_cnt_reg   <= 4'h0;
                    byte_idx_reg  <= idx_inc;
                    state_reg     <= SER_WR;
                end
                SER_RD: begin
                    if (scl_rise) bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (byte_done) begin
                        drive_low_reg <= 1'b0;               // release for ack
                        byte_idx_reg  <= idx_inc;
                        state_reg     <= SER_RD_ACK;
                    end else if (scl_fall) begin
                        shift_reg     <= {shift_reg[6:0], 1'b1};
                        drive_low_reg <= ~shift_reg[6];
                    end
                end
                SER_RD_ACK: begin
                    if (scl_rise) ack_seen_reg <= ~sda_s;
                    if (scl_fall && ack_seen_reg) begin
                        // index was bumped at byte end, so tx_byte is next
                        bit_cnt_reg   <= 4'h0;
                        shift_reg     <= tx_byte;
                        drive_low_reg <= ~tx_byte[7];
                        state_reg     <= SER_RD;
                    end else if (scl_fall) begin
                        state_reg     <= SER_IDLE;       // nack ends read
                    end
                end
                default: state_reg <= SER_IDLE;
            endcase
        end
    end

    // code snapshot at every address match, read or write
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            snap_v_reg <= 12'h000;
            snap_i_reg <= 12'h000;
        end else if (state_reg == SER_ADDR && byte_done && addr_hit) begin
            snap_v_reg <= volt_code;
            snap_i_reg <= amp_code;
        end
    end

    // pointer and configuration registers written over the bus
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cmd_reg      <= `CMD_RESET;
            ext_sel_reg  <= 1'b0;
            ext_ptr_reg  <= 2'd0;
            alert_th_reg <= `ALERT_TH_RESET;
            control_reg  <= `CONTROL_RESET;
        end else begin
            if (wr_cmd) cmd_reg <= shift_reg[6:0];
            if (wr_cmd) ext_sel_reg <= 1'b0;
            if (wr_ptr) ext_sel_reg <= 1'b1;
            if (wr_ptr) ext_ptr_reg <= shift_reg[1:0];
            if (wr_th)  alert_th_reg <= shift_reg;
            if (wr_ctl) control_reg <= shift_reg;
        end
    end

    // alert enable; clear bit self-clears one cycle after its write
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            alert_en_reg <= `ALERT_EN_RESET;
            clear_reg    <= 1'b0;
        end else if (wr_en) begin
            alert_en_reg <= shift_reg;
            clear_reg    <= shift_reg[`EN_CLEAR];
        end else if (clear_reg) begin
            alert_en_reg[`EN_CLEAR] <= 1'b0;
            clear_reg               <= 1'b0;
        end
    end

    // fault delay counter stands in for the timer capacitor charge
    wire delay_done = cmp_s && (delay_cnt_reg == DELAY_LAST);
    always_ff @(posedge ref_clk) begin
        if (srst || !cmp_s) begin
            delay_cnt_reg <= 16'h0000;
        end else if (!delay_done) begin
            delay_cnt_reg <= delay_cnt_reg + 16'h0001;
        end
    end

    // latched status; a set in the clear cycle wins
    wire off_en  = alert_en_reg[`EN_OFF_ALERT];
    wire sw_on   = wr_ctl && shift_reg[`CTL_SOFTWARE_OFF];
    wire sw_low  = wr_ctl && !shift_reg[`CTL_SOFTWARE_OFF];
    wire comp_set = delay_done && alert_en_reg[`EN_COMPARATOR_ALERT_LATCHED];
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            adc_alert_reg  <= 1'b0;
            comp_alert_reg <= 1'b0;
            off_alert_reg  <= 1'b0;
            off_flag_reg   <= 1'b0;
        end else begin
            adc_alert_reg  <= adc_trip | (adc_alert_reg & ~clear_reg);
            comp_alert_reg <= comp_set | (comp_alert_reg & ~clear_reg);
            off_alert_reg  <= (sw_on & off_en)
                              | (off_alert_reg & ~clear_reg);
            off_flag_reg   <= sw_on | (off_flag_reg & ~sw_low);
        end
    end

    // fault level: latched enabled alerts, overridden by software off when off_alert_enable is high
    wire sw_force = control_reg[`CTL_SOFTWARE_OFF] & off_en;
    wire adc_en   = |alert_en_reg[1:0];
    wire fault    = ((adc_alert_reg & adc_en)
                    | (comp_alert_reg & alert_en_reg[`EN_COMPARATOR_ALERT_LATCHED]))
                    & ~sw_force;
    logic alert_oe_reg;
    always_ff @(posedge ref_clk) begin
        if (srst) alert_oe_reg <= 1'b1;
        else      alert_oe_reg <= ~fault;
    end

    // open drain pins only ever pull low
    assign sda_out         = 1'b0;
    assign sda_oe          = drive_low_reg;
    assign alert_out       = 1'b0;
    assign alert_oe        = alert_oe_reg;
    assign conv_command    = cmd_reg;
    assign alert_enable    = alert_en_reg;
    assign alert_threshold = alert_th_reg;
endmodule

// File: tb_top.sv
// self-checking bench: layouts, status byte, fault delay and clearing
// assumes the master model and the checker are compiled before it
`timescale 1ns/1ps
module tb_top;
    import monitor_readback_pkg::*;
    localparam logic [6:0] ADDR = 7'h4A;
    typedef struct {
        logic [7:0]  cmd;
        logic [11:0] v;
        logic [11:0] a;
        int          n;
        logic [23:0] e;
    } row_t;
    logic        ref_clk, srst, scl_low, sda_low, sda_out, sda_oe;
    logic        adc_overcurrent_seen, adc_trip, comparator_overcurrent;
    logic        alert_out, alert_oe, ack, nk;
    logic [11:0] volt_code, amp_code;
    logic [7:0]  alert_enable, alert_threshold, q;
    logic [6:0]  conv_command;
    logic [23:0] got;
    int          mismatches, checked;
    wire         scl_line = ~scl_low;
    wire         sda_line = ~(sda_low | (sda_oe & ~sda_out));
    // command, codes, byte count, expected bytes from the top
    row_t        rows [5] = '{
        '{8'h05, 12'hABC, 12'h123, 3, 24'hAB_12C3},
        '{8'h00, 12'h800, 12'hFFF, 3, 24'h80_FF0F},
        '{8'h01, 12'h5A3, 12'h777, 2, 24'h5A_3000},
        '{8'h04, 12'h111, 12'hE7D, 2, 24'hE7_D000},
        '{8'h01, 12'hFFF, 12'h000, 3, 24'hFF_F0FF}};

    always #50 ref_clk = ~ref_clk;

    monitor_readback_status_alert #(.FAULT_DELAY_CYCLES(8))
    monitor_readback_status_alert_i (
        .ref_clk(ref_clk), .srst(srst), .scl_in(scl_line),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .dev_addr(ADDR), .volt_code(volt_code), .amp_code(amp_code),
        .adc_overcurrent_seen(adc_overcurrent_seen), .adc_trip(adc_trip),
        .comparator_overcurrent(comparator_overcurrent),
        .conv_command(conv_command), .alert_enable(alert_enable),
        .alert_threshold(alert_threshold), .alert_out(alert_out),
        .alert_oe(alert_oe));
    bus_master_model bus_master_model_i (
        .ref_clk(ref_clk), .sda_line(sda_line), .scl_low(scl_low),
        .sda_low(sda_low));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic fin(input string s);
        $display("test %s done, %0d mismatches", s, mismatches);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // command byte alone, or pointer then extended value
    task automatic wr(input logic [7:0] b0, b1, input logic two);
        bus_master_model_i.start();
        bus_master_model_i.byte_io({ADDR, 1'b0}, 1'b1, q, ack);
        bus_master_model_i.byte_io(b0, 1'b1, q, ack);
        if (two)
            bus_master_model_i.byte_io(b1, 1'b1, q, ack);
        bus_master_model_i.stop();
        check(ack, 1'b0);
    endtask
    task automatic rd(input int n, input logic [6:0] a);
        bus_master_model_i.start();
        bus_master_model_i.byte_io({a, 1'b1}, 1'b1, q, ack);
        for (int i = 0; i < n; i++) begin
            bus_master_model_i.byte_io(8'hFF, i == n - 1, q, nk);
            got = {got[15:0], q};
        end
        bus_master_model_i.stop();
    endtask
    task automatic st(input logic [7:0] exp);
        rd(1, ADDR);
        check(got[7:0], exp);
    endtask
    task automatic run_row(input row_t w);
        wr(w.cmd, 8'h00, 1'b0);
        check({1'b0, conv_command}, w.cmd);
        volt_code = w.v;
        amp_code = w.a;
        rd(w.n, ADDR);
        check(ack, 1'b0);
        for (int i = 0; i < w.n; i++) begin
            check(got[8*(w.n-1-i) +: 8], w.e[23-8*i -: 8]);
        end
    endtask
    task automatic do_reset();
        srst = 1'b1;
        cyc(16);
        srst = 1'b0;
        cyc(4);
        check(alert_oe, 1'b1);
        check(alert_out, 1'b0);
        check(sda_oe, 1'b0);
        check(alert_enable, 8'h04);
        check({1'b0, conv_command}, 8'h00);
        check(alert_threshold, 8'hFF);
    endtask
    // comparator held well past the delay, then dropped
    task automatic trip();
        comparator_overcurrent = 1'b1;
        cyc(30);
        comparator_overcurrent = 1'b0;
        cyc(5);
    endtask
    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // hang guard, counted as a mismatch
    initial begin
        repeat (90000) @(posedge ref_clk);
        mismatches++;
        conclude();
    end
    // main sequence
    initial begin
        ref_clk = 1'b0;
        volt_code = 12'h000;
        amp_code = 12'h000;
        adc_overcurrent_seen = 1'b0;
        adc_trip = 1'b0;
        comparator_overcurrent = 1'b0;
        mismatches = 0;
        checked = 0;
        do_reset();
        fin("reset");
        foreach (rows[r])
            run_row(rows[r]);
        fin("layouts");
        wr(8'h40, 8'h00, 1'b0);
        comparator_overcurrent = 1'b1;
        cyc(5);
        comparator_overcurrent = 1'b0;
        cyc(20);
        check(alert_oe, 1'b1);
        st(8'h00);
        adc_overcurrent_seen = 1'b1;
        comparator_overcurrent = 1'b1;
        cyc(4);
        check(alert_oe, 1'b1);
        cyc(26);
        check(alert_oe, 1'b0);
        st(8'h0D);
        adc_overcurrent_seen = 1'b0;
        comparator_overcurrent = 1'b0;
        cyc(20);
        check(alert_oe, 1'b0);
        st(8'h08);
        wr(8'h81, 8'h14, 1'b1);
        check(alert_enable, 8'h04);
        check(alert_oe, 1'b1);
        st(8'h00);
        fin("comparator fault");
        wr(8'h81, 8'h05, 1'b1);
        adc_trip = 1'b1;
        cyc(1);
        adc_trip = 1'b0;
        cyc(5);
        check(alert_oe, 1'b0);
        st(8'h02);
        wr(8'h81, 8'h14, 1'b1);
        st(8'h00);
        fin("converter trip");
        trip();
        wr(8'h83, 8'h01, 1'b1);
        st(8'h18);
        check(alert_oe, 1'b0);
        wr(8'h81, 8'h0C, 1'b1);
        check(alert_oe, 1'b1);
        wr(8'h83, 8'h01, 1'b1);
        st(8'h38);
        wr(8'h81, 8'h1C, 1'b1);
        check(alert_enable, 8'h0C);
        st(8'h10);
        wr(8'h83, 8'h00, 1'b1);
        st(8'h00);
        fin("software off");
        rd(0, ADDR ^ 7'h01);
        check(ack, 1'b1);
        do_reset();
        fin("wrong address and reset");
        conclude();
    end
endmodule
